/* hdl/mu_params.svh */
// Register offsets, field values and timing counts of the serial core
`ifndef MU_PARAMS_SVH
`define MU_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MU_OFF_STAT 8'h00
`define MU_OFF_DATA 8'h04
`define MU_OFF_BRR 8'h08
`define MU_OFF_CTRL 8'h0c
// ----------------------------------------
// Reset values, masks and the mute bit index
// ----------------------------------------
`define MU_STAT_RST 32'h0000_00c0
`define MU_STAT_W1C 32'h0000_035f
`define MU_BRR_RST 16'h0010
`define MU_CTRL_RST 32'h0000_0000
`define MU_RWU_BIT 6
// ----------------------------------------
// Timing counts in oversample ticks
// ----------------------------------------
`define MU_OSR 16'h0010
`define MU_BIT_TICKS 8'h10
`define MU_BRK_TICKS 8'hd0
`define MU_STOP_05 8'h08
`define MU_STOP_15 8'h18
`define MU_STOP_2 8'h20
`define MU_LBD10 8'ha0
`define MU_LBD11 8'hb0
`define MU_IDLE8 8'ha0
`define MU_IDLE9 8'hb0
`define MU_IR_PULSE 4'h3
`define MU_MID_LO 4'h7
`define MU_MID_HI 4'h9
`define MU_END_PH 4'hf
`define MU_STOP_PH 4'ha
// ----------------------------------------
// Stop bit codes
// ----------------------------------------
`define MU_SB_1 2'h0
`define MU_SB_05 2'h1
`define MU_SB_2 2'h2
`define MU_SB_15 2'h3
`endif

/* hdl/mu_pkg.sv */
// Types of the serial core
package mu_pkg;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_BRK = 3'b001,
        TX_START = 3'b010,
        TX_DATA = 3'b011,
        TX_STOP = 3'b100
    } mu_tx_st_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } mu_rx_st_t;
    typedef struct packed {
        logic [7:0] rsv;
        logic [3:0] addr;
        logic dmar, dmat, ctse, rtse, clken, scen, hd, iren;
        logic [1:0] stop;
        logic lbdl, lin, sbk, rwu, wake, ps, pce, m, re, te;
    } mu_ctrl_t;
    typedef struct packed {
        logic [21:0] rsv;
        logic ctsc, lbd, txe, tc, rxne, idle, ore, ne, fe, pe;
    } mu_stat_t;
endpackage

/* hdl/mu_baud.sv */
// Fractional oversample tick generator
`timescale 1ns/1ps
`include "mu_params.svh"
module mu_baud #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic en,
    input wire logic [W-1:0] div,
    // Tick out
    output logic tick
);
    logic [W-1:0] acc;
    logic [W:0] sum, dv;
    assign dv = (div < W'(`MU_OSR)) ? (W+1)'(`MU_OSR) : {1'b0, div};
    assign sum = {1'b0, acc} + (W+1)'(`MU_OSR);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
            tick <= 1'b0;
        end else if (!en) begin
            acc <= '0;
            tick <= 1'b0;
        end else if (sum >= dv) begin
            acc <= W'(sum - dv);
            tick <= 1'b1;
        end else begin
            acc <= W'(sum);
            tick <= 1'b0;
        end
    end
endmodule // mu_baud

/* hdl/mu_irda.sv */
// Infrared pulse encoder and decoder
`timescale 1ns/1ps
`include "mu_params.svh"
module mu_irda (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic iren,
    input wire logic tick,
    // Transmit side
    input wire logic tx_bit,
    input wire logic tx_act,
    input wire logic [3:0] ph,
    output logic tx_line,
    // Receive side
    input wire logic line_i,
    output logic rx_bit
);
    logic [4:0] hold;
    // Zero bit as short high pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_line <= 1'b1;
        end else if (iren) begin
            tx_line <= tx_act & ~tx_bit & (ph < `MU_IR_PULSE); // R7
        end else begin
            tx_line <= tx_bit;
        end
    end
    // Pulse stretched to a full low bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 5'h00;
        end else if (iren && line_i) begin
            hold <= 5'h10; // R7
        end else if (tick && hold != 5'h00) begin
            hold <= hold - 5'h01;
        end
    end
    assign rx_bit = iren ? (hold == 5'h00) : line_i;
endmodule // mu_irda

/* hdl/mu_usart.sv */
// Multimode serial receiver and transmitter with APB registers
// Notes on behaviour
// (R1) Word length of 8 or 9 bits for transmit and receive.
// (R2) One or two stop bits sent and expected; the receiver checks only the first stop bit.
// (R3) Smart card mode adds half and one and a half stop bits.
// (R4) In LIN mode a break is sent on request.
// (R5) A sent break is 13 bit times low.
// (R6) LIN receiver flags a low of 10 or 11 bit times.
// (R7) Infrared zero is a pulse of 3/16 bit; decoder accepts it.
// (R8) One fractional divider sets the common bit rate.
// (R9) Transmitter and receiver enable separately.
// (R10) Unmatched address puts receiver silent, hiding its events; the code still sets the LIN break flag lbd while silent.
// (R11) Silence ends by address mark bit or idle line, selectable.
// (R12) Overrun, noise, framing and parity errors are flagged.
// (R13) Ten flagged event sources.
// (R14) Flags for receive full, transmit empty, transmission complete.
// (R15) Parity appended on send and checked on receive.
// (R16) Synchronous mode drives a clock with data bits.
// (R17) CTS pauses sending; RTS released when receive data is unread.
// (R18) Half duplex shares one line, driven only while sending.
// (R19) DMA requests for transmit empty and receive full.
// (R20) Smart card uses the single half duplex line.
// (R21) Low start bit, data LSB first, idle line high.
// (R22) Idle flag after one character time high following activity.
`timescale 1ns/1ps
`include "mu_params.svh"
module mu_usart
    import mu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial lines
    input wire logic rxd,
    input wire logic txd_i,
    output logic txd_o,
    output logic txd_oe,
    output logic ser_clk,
    input wire logic cts_n,
    output logic rts_n,
    // DMA requests
    output logic dma_tx_req,
    output logic dma_rx_req
);
    mu_ctrl_t ctrl;
    mu_stat_t stat, st_set, st_clr;
    mu_tx_st_t tx_st;
    mu_rx_st_t rx_st;
    logic [15:0] brr;
    logic [31:0] ctrl_rd;
    logic [8:0] tx_buf, tx_sh, tx_load, rx_sh, rx_w, rx_data;
    logic [7:0] tx_ph, tx_lim, stop_lim, idle_cnt, low_cnt, brk_cnt;
    logic [3:0] nb, tx_cnt, rx_ph, rx_cnt, dec_ph;
    logic [2:0] smp;
    logic wr, rd, ok, data_wr, data_rd, tick, mute, cts_d, cts_ok;
    logic tx_bit, tx_end, tx_go, tc_ev, brk_done, rx_line, rx_bit;
    logic rx_ev, rx_done, maj, noisy, nz, armed, msb, hit, deliver;
    logic idle_arm, idle_hit, lbd_hit;
    // ----------------------------------------
    // APB access
    // ----------------------------------------
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign ok = (paddr == `MU_OFF_STAT) || (paddr == `MU_OFF_DATA) ||
        (paddr == `MU_OFF_BRR) || (paddr == `MU_OFF_CTRL);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~ok;
    assign data_wr = wr && paddr == `MU_OFF_DATA;
    assign data_rd = rd && paddr == `MU_OFF_DATA;
    assign ctrl_rd = {ctrl[31:7], mute, ctrl[5:0]};
    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `MU_OFF_STAT) begin
                prdata <= stat;
            end else if (paddr == `MU_OFF_DATA) begin
                prdata <= {23'h0, rx_data};
            end else if (paddr == `MU_OFF_BRR) begin
                prdata <= {16'h0000, brr};
            end else if (paddr == `MU_OFF_CTRL) begin
                prdata <= ctrl_rd;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
    // Control and divider registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `MU_CTRL_RST;
            brr <= `MU_BRR_RST;
        end else begin
            if (wr && paddr == `MU_OFF_CTRL) begin
                ctrl <= pwdata;
            end else if (brk_done) begin
                ctrl.sbk <= 1'b0;
            end
            if (wr && paddr == `MU_OFF_BRR) begin
                brr <= pwdata[15:0];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf <= 9'h000;
        end else if (data_wr) begin
            tx_buf <= pwdata[8:0];
        end
    end
    // ----------------------------------------
    // Bit rate and infrared coding
    // ----------------------------------------
    mu_baud #(.W(16)) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .en(ctrl.te | ctrl.re), // R9
        .div(brr), // R8
        .tick(tick)
    );
    assign rx_line = (ctrl.hd | ctrl.scen) ? txd_i : rxd; // R18 R20
    mu_irda u_irda (
        .pclk(pclk),
        .presetn(presetn),
        .iren(ctrl.iren),
        .tick(tick),
        .tx_bit(tx_bit),
        .tx_act(tx_st != TX_IDLE),
        .ph(tx_ph[3:0]),
        .tx_line(txd_o),
        .line_i(rx_line),
        .rx_bit(rx_bit)
    );
    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    assign nb = ctrl.m ? 4'h9 : 4'h8; // R1
    always_comb begin
        case (ctrl.stop)
            `MU_SB_05: stop_lim = ctrl.scen ? `MU_STOP_05 : `MU_BIT_TICKS; // R3
            `MU_SB_2: stop_lim = `MU_STOP_2; // R2
            `MU_SB_15: stop_lim = ctrl.scen ? `MU_STOP_15 : `MU_STOP_2; // R3
            default: stop_lim = `MU_BIT_TICKS; // R2
        endcase
    end
    always_comb begin
        case (tx_st)
            TX_BRK: tx_lim = `MU_BRK_TICKS; // R5
            TX_STOP: tx_lim = stop_lim;
            default: tx_lim = `MU_BIT_TICKS;
        endcase
    end
    always_comb begin
        if (!ctrl.pce) begin
            tx_load = ctrl.m ? tx_buf : {1'b0, tx_buf[7:0]};
        end else if (ctrl.m) begin
            tx_load = {^tx_buf[7:0] ^ ctrl.ps, tx_buf[7:0]}; // R15
        end else begin
            tx_load = {1'b0, ^tx_buf[6:0] ^ ctrl.ps, tx_buf[6:0]}; // R15
        end
    end
    always_comb begin
        case (tx_st)
            TX_DATA: tx_bit = tx_sh[0]; // R21
            TX_START: tx_bit = 1'b0; // R21
            TX_BRK: tx_bit = 1'b0; // R5
            default: tx_bit = 1'b1;
        endcase
    end
    assign cts_ok = !ctrl.ctse || !cts_n; // R17
    assign tx_end = tick && tx_ph == tx_lim - 8'h01;
    assign tx_go = tx_st == TX_IDLE && ctrl.te && !(ctrl.sbk && ctrl.lin) &&
        !stat.txe && cts_ok; // R9 R17
    assign tc_ev = tx_end && tx_st == TX_STOP && stat.txe; // R14
    assign brk_done = tx_end && tx_st == TX_BRK;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st <= TX_IDLE;
            tx_ph <= 8'h00;
            tx_cnt <= 4'h0;
            tx_sh <= 9'h000;
        end else if (tx_st == TX_IDLE) begin
            tx_ph <= 8'h00;
            tx_cnt <= 4'h0;
            if (ctrl.te && ctrl.sbk && ctrl.lin) begin
                tx_st <= TX_BRK; // R4
            end else if (tx_go) begin
                tx_st <= TX_START;
                tx_sh <= tx_load;
            end
        end else if (tx_end) begin
            tx_ph <= 8'h00;
            case (tx_st)
                TX_START: tx_st <= TX_DATA;
                TX_DATA: begin
                    tx_sh <= {1'b1, tx_sh[8:1]}; // R21
                    tx_cnt <= tx_cnt + 4'h1;
                    if (tx_cnt == nb - 4'h1) begin
                        tx_st <= TX_STOP; // R1
                    end
                end
                TX_BRK: tx_st <= TX_STOP;
                default: tx_st <= TX_IDLE;
            endcase
        end else if (tick) begin
            tx_ph <= tx_ph + 8'h01;
        end
    end
    // Pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_oe <= 1'b0;
            ser_clk <= 1'b0;
            rts_n <= 1'b0;
            cts_d <= 1'b1;
        end else begin
            txd_oe <= (ctrl.hd || ctrl.scen) ? tx_st != TX_IDLE : 1'b1; // R18 R20
            ser_clk <= ctrl.clken && tx_st == TX_DATA && tx_ph[3]; // R16
            rts_n <= ctrl.rtse && stat.rxne; // R17
            cts_d <= cts_n;
        end
    end
    assign dma_tx_req = ctrl.dmat & stat.txe; // R19
    assign dma_rx_req = ctrl.dmar & stat.rxne; // R19
    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    assign maj = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
    assign noisy = |smp && !(&smp); // R12
    assign dec_ph = (rx_st == RX_STOP) ? `MU_STOP_PH : `MU_END_PH;
    assign rx_ev = tick && rx_st != RX_IDLE && rx_ph == dec_ph;
    assign rx_done = rx_ev && rx_st == RX_STOP;
    assign rx_w = ctrl.m ? rx_sh : {1'b0, rx_sh[8:1]}; // R1
    assign msb = ctrl.m ? rx_w[8] : rx_w[7]; // R11
    assign hit = rx_w[3:0] == ctrl.addr;
    assign deliver = rx_done && !mute && !(ctrl.wake && msb && !hit); // R10
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st <= RX_IDLE;
            rx_ph <= 4'h0;
            rx_cnt <= 4'h0;
            rx_sh <= 9'h000;
            smp <= 3'h7;
            nz <= 1'b0;
            armed <= 1'b0;
        end else if (rx_st == RX_IDLE) begin
            rx_ph <= 4'h0;
            rx_cnt <= 4'h0;
            nz <= 1'b0;
            armed <= rx_bit | (armed & ctrl.re);
            if (ctrl.re && armed && !rx_bit) begin
                rx_st <= RX_START; // R21
                armed <= 1'b0;
            end
        end else if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph >= `MU_MID_LO && rx_ph <= `MU_MID_HI) begin
                smp <= {smp[1:0], rx_bit};
            end
            if (rx_ev) begin
                rx_ph <= 4'h0;
                nz <= nz | noisy;
                case (rx_st)
                    RX_START: rx_st <= maj ? RX_IDLE : RX_DATA;
                    RX_DATA: begin
                        rx_sh <= {maj, rx_sh[8:1]}; // R21
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_cnt == nb - 4'h1) begin
                            rx_st <= RX_STOP;
                        end
                    end
                    default: rx_st <= RX_IDLE;
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data <= 9'h000;
        end else if (deliver && !(stat.rxne && !data_rd)) begin
            rx_data <= rx_w;
        end
    end
    // Silent mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute <= 1'b0;
        end else if (wr && paddr == `MU_OFF_CTRL) begin
            mute <= pwdata[`MU_RWU_BIT];
        end else if (rx_done && ctrl.wake && msb) begin
            mute <= !hit; // R10 R11
        end else if (idle_hit && !ctrl.wake) begin
            mute <= 1'b0; // R11
        end
    end
    // Idle line and break timing
    assign idle_hit = tick && idle_arm && rx_st == RX_IDLE && rx_bit &&
        idle_cnt == (ctrl.m ? `MU_IDLE9 : `MU_IDLE8) - 8'h01; // R22
    assign lbd_hit = ctrl.lin && tick && !rx_bit &&
        low_cnt == (ctrl.lbdl ? `MU_LBD11 : `MU_LBD10) - 8'h01; // R6
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt <= 8'h00;
            idle_arm <= 1'b0;
            low_cnt <= 8'h00;
        end else begin
            if (rx_st != RX_IDLE || !rx_bit) begin
                idle_cnt <= 8'h00;
            end else if (tick && idle_cnt != 8'hff) begin
                idle_cnt <= idle_cnt + 8'h01;
            end
            if (rx_done) begin
                idle_arm <= 1'b1;
            end else if (idle_hit) begin
                idle_arm <= 1'b0;
            end
            if (rx_bit) begin
                low_cnt <= 8'h00;
            end else if (tick && low_cnt != 8'hff) begin
                low_cnt <= low_cnt + 8'h01;
            end
        end
    end
    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_comb begin
        st_set = '0;
        st_clr = '0;
        st_set.pe = deliver && ctrl.pce && (^rx_w != ctrl.ps); // R12 R15
        st_set.fe = deliver && !maj; // R12
        st_set.ne = deliver && (nz || noisy); // R12
        st_set.ore = deliver && stat.rxne && !data_rd; // R12
        st_set.rxne = deliver && !(stat.rxne && !data_rd); // R14
        st_set.idle = idle_hit && !mute; // R22
        st_set.txe = tx_go; // R14
        st_set.tc = tc_ev; // R14
        st_set.lbd = lbd_hit; // R6
        st_set.ctsc = cts_d != cts_n; // R13
        if (wr && paddr == `MU_OFF_STAT) begin
            st_clr = pwdata & `MU_STAT_W1C;
        end
        st_clr.txe = data_wr;
        st_clr.tc = st_clr.tc | data_wr;
        st_clr.rxne = data_rd;
    end
    // Set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat <= `MU_STAT_RST;
        end else begin
            stat <= mu_stat_t'((stat & ~st_clr) | st_set); // R13
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_cnt <= 8'h00;
        end else if (tx_st != TX_BRK) begin
            brk_cnt <= 8'h00;
        end else if (tick) begin
            brk_cnt <= brk_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_start;
        tx_st == TX_IDLE ##1 tx_st == TX_START;
    endsequence
    sequence s_brk_last;
        tx_st == TX_BRK && tick && brk_cnt == 8'hcf;
    endsequence
    a_start_low: assert property (s_start |=> (ctrl.iren || !txd_o)) // R21
        else $error("start bit not low");
    a_idle_high: assert property ((tx_st == TX_IDLE && !ctrl.iren) |=> txd_o) // R21
        else $error("idle line not high");
    a_break_len: assert property (s_brk_last |=> tx_st == TX_STOP) // R5
        else $error("break length wrong");
    a_break_low: assert property (tx_st == TX_BRK ##1 !ctrl.iren |-> !txd_o) // R4
        else $error("break not low");
    a_cts_hold: assert property ((tx_st == TX_IDLE && ctrl.ctse && cts_n) |=>
        tx_st != TX_START) // R17
        else $error("sent while cts high");
    a_rts_full: assert property ((ctrl.rtse && stat.rxne) |=> rts_n) // R17
        else $error("rts not released");
    a_hd_release: assert property (((ctrl.hd || ctrl.scen) && tx_st == TX_IDLE) |=>
        !txd_oe) // R18
        else $error("line driven while idle");
    a_ovr_flag: assert property ((deliver && stat.rxne && !data_rd) |=>
        stat.ore && $stable(rx_data)) // R12
        else $error("overrun missed");
    a_mute_quiet: assert property ((rx_done && mute && !ctrl.wake) |=>
        !$rose(stat.rxne)) // R10
        else $error("event while silent");
    a_lbd_flag: assert property (lbd_hit |=> stat.lbd) // R6
        else $error("break not flagged");
    a_sclk_off: assert property (!ctrl.clken |=> !ser_clk) // R16
        else $error("clock out while off");
    a_tc_flag: assert property (tc_ev |=> stat.tc ##1 stat.tc || data_wr ||
        $past(wr)) // R14
        else $error("complete not flagged");
endmodule // mu_usart

/* hdl/mu_none.sv */
// Intentionally no content
`timescale 1ns/1ps

/* testbench/mu_node.sv */
// Remote serial node model facing the core
`timescale 1ns/1ps
module mu_node (
    // Clock
    input wire logic pclk,
    // Serial lines
    input wire logic txd,
    output logic rxd
);
    localparam int BIT = 16;
    initial rxd = 1'b1;
    // Hold a level for n cycles
    task automatic drive(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge pclk);
    endtask
    // Start low, data lsb first, stop level, then idle high
    task automatic send(input logic [8:0] w, input int nb, input logic stp);
        drive(1'b0, BIT);
        for (int i = 0; i < nb; i++) drive(w[i], BIT);
        drive(stp, BIT);
        drive(1'b1, BIT);
    endtask
    // Sample eleven bit times mid bit from a start edge
    task automatic grab(output logic [10:0] f);
        @(negedge txd);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd;
            repeat (BIT) @(posedge pclk);
        end
    endtask
    // Count cycles of one low period
    task automatic lowlen(output int n);
        n = 0;
        @(negedge txd);
        @(posedge pclk);
        while (txd === 1'b0) begin
            n++;
            @(posedge pclk);
        end
    endtask
endmodule // mu_node

/* testbench/mu_usart_tb.sv */
// Testbench of the multimode serial core
`timescale 1ns/1ps
`include "mu_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module mu_usart_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cts_n = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, rxd, txd_o, txd_oe, ser_clk, rts_n, dtx, drx, e;
    logic [10:0] f;
    int n_fail = 0, checked = 0, n;
    wire logic line = txd_oe ? txd_o : 1'b1;
    always #5 pclk = ~pclk;
    mu_usart DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_i(line), .txd_o(txd_o),
        .txd_oe(txd_oe), .ser_clk(ser_clk), .cts_n(cts_n), .rts_n(rts_n),
        .dma_tx_req(dtx), .dma_rx_req(drx));
    mu_node node (.pclk(pclk), .txd(line), .rxd(rxd));
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic clr;
        apb(1'b1, `MU_OFF_STAT, `MU_STAT_W1C);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        stop_test;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("stat", 32'h0000_00c0, r)
        apb(1'b0, `MU_OFF_BRR, 32'h0);
        `CHK("brr", 32'h0000_0010, r)
        apb(1'b0, `MU_OFF_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, r)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("slverr", 1'b1, e)
        $display("reset test done");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `MU_OFF_CTRL, 32'h1 | (k << 2));
            fork
                node.grab(f);
                apb(1'b1, `MU_OFF_DATA, 32'h1a5);
            join
            `CHK("frame", k ? {1'b1, 9'h1a5, 1'b0} : {2'b11, 8'ha5, 1'b0}, f)
        end
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("tc txe", 32'hc0, r & 32'hc0)
        $display("transmit test done");
        clr;
        apb(1'b1, `MU_OFF_CTRL, 32'h80002);
        node.send(9'h03c, 8, 1'b1);
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("rxne", 32'h20, r & 32'h2f)
        `CHK("dma rx", 1'b1, drx)
        apb(1'b0, `MU_OFF_DATA, 32'h0);
        `CHK("data", 32'h3c, r)
        @(posedge pclk);
        `CHK("dma rx off", 1'b0, drx)
        repeat (170) @(posedge pclk);
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("idle", 32'h10, r & 32'h10)
        $display("receive test done");
        clr;
        apb(1'b1, `MU_OFF_CTRL, 32'ha);
        node.send(9'h001, 8, 1'b1);
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("parity", 32'h1, r & 32'h1)
        clr;
        node.send(9'h081, 8, 1'b1);
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("overrun", 32'h8, r & 32'hb)
        clr;
        apb(1'b0, `MU_OFF_DATA, 32'h0);
        node.send(9'h055, 8, 1'b0);
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("framing", 32'h2, r & 32'h3)
        $display("error test done");
        fork
            node.lowlen(n);
            apb(1'b1, `MU_OFF_CTRL, 32'h181);
        join
        `CHK("break len", 13 * 16, n)
        for (int k = 0; k < 2; k++) begin
            clr;
            apb(1'b1, `MU_OFF_CTRL, 32'h102 | (k << 9));
            node.drive(1'b0, 170);
            node.drive(1'b1, 32);
            apb(1'b0, `MU_OFF_STAT, 32'h0);
            `CHK("break det", k ? 32'h0 : 32'h100, r & 32'h100)
        end
        $display("line break test done");
        cts_n <= 1'b1;
        apb(1'b1, `MU_OFF_CTRL, 32'h78001);
        apb(1'b1, `MU_OFF_DATA, 32'h11);
        fork
            node.grab(f);
            begin
                repeat (40) @(posedge pclk);
                `CHK("cts hold", 1'b1, txd_o)
                `CHK("dma tx busy", 1'b0, dtx)
                cts_n <= 1'b0;
                repeat (22) @(posedge pclk);
                `CHK("sclk low", 1'b0, ser_clk)
                repeat (8) @(posedge pclk);
                `CHK("sclk high", 1'b1, ser_clk)
            end
        join
        `CHK("cts frame", {2'b11, 8'h11, 1'b0}, f)
        `CHK("dma tx", 1'b1, dtx)
        `CHK("rts full", 1'b1, rts_n)
        apb(1'b0, `MU_OFF_DATA, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("rts free", 1'b0, rts_n)
        $display("flow test done");
        apb(1'b1, `MU_OFF_CTRL, 32'h42);
        node.send(9'h0aa, 8, 1'b1);
        apb(1'b0, `MU_OFF_STAT, 32'h0);
        `CHK("silent", 32'h0, r & 32'h20)
        repeat (150) @(posedge pclk);
        apb(1'b0, `MU_OFF_CTRL, 32'h0);
        `CHK("wake idle", 32'h0, r & 32'h40)
        apb(1'b1, `MU_OFF_CTRL, 32'h2001);
        repeat (2) @(posedge pclk);
        `CHK("line release", 1'b0, txd_oe)
        $display("mode test done");
        stop_test;
    end
endmodule // mu_usart_tb
